// ---- include/sli_defs.svh ----
/*
 Constants for the serial link init and lock block: frame layout,
 timing counts and reset values.
 Assumes a 200 MHz system clock and a serial bit clock on its own port.
*/
`ifndef SLI_DEFS_SVH
`define SLI_DEFS_SVH

// Frame layout, bit 0 leaves the line first
`define SLI_WORD_W 24
`define SLI_FRAME_W 28
`define SLI_POS_ONE 0
`define SLI_POS_PAY 1
`define SLI_POS_BAL 25
`define SLI_POS_CHK 26
`define SLI_POS_ZERO 27
`define SLI_LAST_BIT 5'h1b
`define SLI_HALF_ONES 8'sh0c

// Word clock range and its period in system clock cycles
`define SLI_CLK_HZ 200000000
`define SLI_TRANSMIT_WORD_CLOCK_MIN_HZ 3000000
`define SLI_TRANSMIT_WORD_CLOCK_MAX_HZ 40000000
`define SLI_PER_W 7
`define SLI_PER_MAX (`SLI_CLK_HZ / `SLI_TRANSMIT_WORD_CLOCK_MIN_HZ)
`define SLI_PER_MIN \
  ((`SLI_CLK_HZ + `SLI_TRANSMIT_WORD_CLOCK_MAX_HZ - 1) / `SLI_TRANSMIT_WORD_CLOCK_MAX_HZ)

// Lock criteria and output strobe timing
`define SLI_TX_LOCK_EDGES 4'h8
`define SLI_RX_LOCK_FRAMES 3'h4
`define SLI_RCLK_HALF 3'h2

// Reset values
`define SLI_WORD_RST 24'h000000
`define SLI_RD_RST 8'sh00

`endif

// ---- include/sli_pkg.sv ----
/*
 Types and shared functions for the serial link init and lock block.
 Assumes sli_defs.svh is on the include path.
*/
`include "sli_defs.svh"

package sli_pkg;

  typedef logic [`SLI_WORD_W-1:0] sli_word_t;
  typedef logic [`SLI_FRAME_W-1:0] sli_frame_t;

  typedef enum logic [1:0] {
    SLI_HUNT,
    SLI_VERIFY,
    SLI_LOCKED
  } sli_rx_state_e;

  // Count of ones in a payload word
  function automatic logic [4:0] sli_ones(input sli_word_t w);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < `SLI_WORD_W; i++) begin
      n = n + {4'h0, w[i]};
    end
    return n;
  endfunction

  // Frame shape and even parity over payload, balance and check
  function automatic logic sli_frame_ok(input sli_frame_t f);
    return f[`SLI_POS_ONE] & ~f[`SLI_POS_ZERO] &
           ~(^f[`SLI_POS_CHK:`SLI_POS_PAY]);
  endfunction

endpackage

// ---- core/sli_cdc_word.sv ----
/*
 Toggle handshake carrying one word from a source clock to a destination
 clock. Assumes the source holds nothing itself: the word is latched here
 and stays still until the destination has acknowledged it.
*/
`timescale 1ns/1ps
`default_nettype none

module sli_cdc_word (
  input wire logic src_clk,
  input wire logic src_rst_b,
  input wire logic src_valid,
  input wire sli_pkg::sli_word_t src_data,
  output logic src_ready,
  input wire logic dst_clk,
  input wire logic dst_rst_b,
  output logic dst_valid,
  output sli_pkg::sli_word_t dst_data
);
  import sli_pkg::*;

  logic req_tog_r;
  logic ack_m_r;
  logic ack_s_r;
  sli_word_t hold_r;
  logic req_m_r;
  logic req_s_r;
  logic req_d_r;

  ////////////////////////////////////////////////////////////////////////
  // Source side: one word in flight at a time
  assign src_ready = (ack_s_r == req_tog_r);

  always_ff @(posedge src_clk) begin
    if (!src_rst_b) begin
      req_tog_r <= 1'b0;
      hold_r <= `SLI_WORD_RST;
    end else if (src_valid && src_ready) begin
      req_tog_r <= ~req_tog_r;
      hold_r <= src_data;
    end
  end

  // Acknowledge returns through two flops
  always_ff @(posedge src_clk) begin
    if (!src_rst_b) begin
      ack_m_r <= 1'b0;
      ack_s_r <= 1'b0;
    end else begin
      ack_m_r <= req_d_r;
      ack_s_r <= ack_m_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Destination side: hold_r is stable once the toggle is seen
  always_ff @(posedge dst_clk) begin
    if (!dst_rst_b) begin
      req_m_r <= 1'b0;
      req_s_r <= 1'b0;
      req_d_r <= 1'b0;
    end else begin
      req_m_r <= req_tog_r;
      req_s_r <= req_m_r;
      req_d_r <= req_s_r;
    end
  end

  // Capture pulse and word
  always_ff @(posedge dst_clk) begin
    if (!dst_rst_b) begin
      dst_valid <= 1'b0;
      dst_data <= `SLI_WORD_RST;
    end else begin
      dst_valid <= req_s_r ^ req_d_r;
      if (req_s_r ^ req_d_r) begin
        dst_data <= hold_r;
      end
    end
  end

endmodule

`default_nettype wire

// ---- core/sli_top.sv ----
/*
 Serializer and deserializer logic of an embedded-clock 24-bit link:
 word clock lock, frame coding and shifting, frame hunt and lock,
 recovered word and clock output with output gating.
 Assumes link_clk is the serial bit clock (one bit per rising edge) supplied by
 the analog front end, and that the line drivers decode the enables.
*/
// Summary of operation
// - One 24-bit word per word clock becomes one serial frame and back
// - Word clock accepted only between 3 and 40 MHz
// - Lock flag high when locked; unlocked floats data and clock outputs
// - Receiver locks from the serial data alone, no reference clock
// - Receiver locks on any payload pattern, no training needed
// - Transmitter locks to its word clock before receiver can sync
// - Reset floats serial and receiver outputs, holds both lock flags low, logic idle
// - Serial output floats until word clock lock, then sends
// - Receiver outputs float while receiver still acquiring
// - Lock flag stays low until frames have been found and checked
// - Transmitter sends ordinary frames during receiver acquisition
// - Receiver retimes the coded bit stream into frames
// - Lock declared only after the rising clock edge is validated
// - Lock time varies with data; lock flag marks its end
// - Lock flag rises together with first valid word and clock
// - Frame holds payload, one bit, zero bit, balance and check bits
// - Frame shifts out at 28 bits per word
// - One missing edge drops lock and restarts the hunt
// - Output enable, sleep and spare_config_input gate the receiver outputs
`timescale 1ns/1ps
`default_nettype none

module sli_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic link_clk,
  input wire logic transmit_word_clock,
  input wire sli_pkg::sli_word_t tx_word_in,
  output logic serial_out_pos,
  output logic serial_out_neg,
  output logic serial_out_oe_n,
  output logic tx_locked,
  input wire logic serial_in_pos,
  input wire logic serial_in_neg,
  input wire logic rx_output_enable,
  input wire logic rx_strobe_edge_select,
  input wire logic rx_sleep_n,
  input wire logic spare_config_input,
  output sli_pkg::sli_word_t parallel_word_out,
  output logic recovered_clock_out,
  output logic rx_outputs_oe_n,
  output logic rx_lock
);
  import sli_pkg::*;

  // Link domain reset
  logic lrst_m_r;
  logic lrst_b;
  // Word clock front end
  logic transmit_word_clock_m_r;
  logic transmit_word_clock_s_r;
  logic transmit_word_clock_d_r;
  sli_word_t word_m_r;
  sli_word_t word_s_r;
  logic transmit_word_clock_rise;
  logic [`SLI_PER_W-1:0] per_cnt_r;
  logic [3:0] edge_cnt_r;
  logic tx_lock_r;
  logic per_good;
  sli_word_t tx_cap_r;
  logic tx_pend_r;
  logic tx_src_ready;
  // Transmit link side
  logic tlk_m_r;
  logic tlk_s_r;
  logic tx_new_v;
  sli_word_t tx_new_word;
  sli_word_t cur_word_r;
  logic [4:0] tx_bit_r;
  sli_frame_t tx_frame_r;
  logic tx_oe_n_r;
  logic signed [7:0] rd_r;
  logic signed [7:0] word_disp;
  logic tx_inv;
  sli_word_t tx_pay;
  sli_frame_t tx_frame_nxt;
  // Receive link side
  logic rin_pm_r;
  logic rin_ps_r;
  logic rin_nm_r;
  logic rin_ns_r;
  logic rsl_m_r;
  logic rsl_s_r;
  logic rx_bit;
  sli_frame_t rx_sr_r;
  logic rx_ok;
  sli_rx_state_e rx_state_r;
  logic [4:0] rx_cnt_r;
  logic [2:0] rx_good_r;
  logic rx_emit_r;
  sli_word_t rx_emit_word_r;
  // Receive system side
  logic lk_m_r;
  logic lk_s_r;
  logic [3:0] ctl_m_r;
  logic [3:0] ctl_s_r;
  logic rx_new_v;
  sli_word_t rx_new_word;
  logic rx_lock_r;
  logic rx_lock_nxt;
  sli_word_t word_out_r;
  logic rclk_r;
  logic [2:0] half_cnt_r;
  logic rx_oe_n_r;

  ////////////////////////////////////////////////////////////////////////
  // Reset into the link domain; plain flops so no port reaches a reset
  always_ff @(posedge link_clk) begin
    lrst_m_r <= rst_b;
    lrst_b <= lrst_m_r;
  end

  ////////////////////////////////////////////////////////////////////////
  // Word clock and word pins pass two flops before use
  always_ff @(posedge clk) begin
    transmit_word_clock_m_r <= transmit_word_clock;
    transmit_word_clock_s_r <= transmit_word_clock_m_r;
    word_m_r <= tx_word_in;
    word_s_r <= word_m_r;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      transmit_word_clock_d_r <= 1'b0;
    end else begin
      transmit_word_clock_d_r <= transmit_word_clock_s_r;
    end
  end

  assign transmit_word_clock_rise = transmit_word_clock_s_r & ~transmit_word_clock_d_r;
  assign per_good = (per_cnt_r >= `SLI_PER_W'(`SLI_PER_MIN)) &&
                    (per_cnt_r <= `SLI_PER_W'(`SLI_PER_MAX));

  // Period meter; saturates so a stopped clock reads as too slow
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      per_cnt_r <= '0;
    end else if (transmit_word_clock_rise) begin
      per_cnt_r <= `SLI_PER_W'(1);
    end else if (per_cnt_r <= `SLI_PER_W'(`SLI_PER_MAX)) begin
      per_cnt_r <= per_cnt_r + `SLI_PER_W'(1);
    end
  end

  // Transmit loop lock: a run of in-range periods, lost on any bad one
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      edge_cnt_r <= 4'h0;
      tx_lock_r <= 1'b0;
    end else if (!per_good && !transmit_word_clock_rise &&
                 per_cnt_r > `SLI_PER_W'(`SLI_PER_MAX)) begin
      edge_cnt_r <= 4'h0;
      tx_lock_r <= 1'b0;
    end else if (transmit_word_clock_rise) begin
      if (!per_good) begin
        edge_cnt_r <= 4'h0;
        tx_lock_r <= 1'b0;
      end else if (edge_cnt_r == `SLI_TX_LOCK_EDGES - 4'h1) begin
        tx_lock_r <= 1'b1;
      end else begin
        edge_cnt_r <= edge_cnt_r + 4'h1;
      end
    end
  end

  assign tx_locked = tx_lock_r;

  // Newest captured word waits for the crossing; older ones are replaced
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_cap_r <= `SLI_WORD_RST;
      tx_pend_r <= 1'b0;
    end else if (transmit_word_clock_rise && tx_lock_r) begin
      tx_cap_r <= word_s_r;
      tx_pend_r <= 1'b1;
    end else if (tx_src_ready) begin
      tx_pend_r <= 1'b0;
    end
  end

  sli_cdc_word u_tx_cdc (
    .src_clk(clk),
    .src_rst_b(rst_b),
    .src_valid(tx_pend_r),
    .src_data(tx_cap_r),
    .src_ready(tx_src_ready),
    .dst_clk(link_clk),
    .dst_rst_b(lrst_b),
    .dst_valid(tx_new_v),
    .dst_data(tx_new_word)
  );

  ////////////////////////////////////////////////////////////////////////
  // Transmit lock level into the link domain
  always_ff @(posedge link_clk) begin
    if (!lrst_b) begin
      tlk_m_r <= 1'b0;
      tlk_s_r <= 1'b0;
    end else begin
      tlk_m_r <= tx_lock_r;
      tlk_s_r <= tlk_m_r;
    end
  end

  // Last word received is repeated if the next has not arrived yet
  always_ff @(posedge link_clk) begin
    if (!lrst_b) begin
      cur_word_r <= `SLI_WORD_RST;
    end else if (tx_new_v) begin
      cur_word_r <= tx_new_word;
    end
  end

  // Balance choice: invert when the word pushes disparity further out
  assign word_disp = $signed({2'b00, sli_ones(cur_word_r), 1'b0}) -
                     `SLI_HALF_ONES - `SLI_HALF_ONES;
  assign tx_inv = ((rd_r > 8'sh00) && (word_disp > 8'sh00)) ||
                  ((rd_r < 8'sh00) && (word_disp < 8'sh00));
  assign tx_pay = cur_word_r ^ {`SLI_WORD_W{tx_inv}};
  assign tx_frame_nxt = {1'b0, ^{tx_pay, tx_inv}, tx_inv, tx_pay,
                         1'b1};

  // Frame shifter; oe only changes on a frame boundary
  always_ff @(posedge link_clk) begin
    if (!lrst_b) begin
      tx_bit_r <= 5'h00;
      tx_frame_r <= '0;
      tx_oe_n_r <= 1'b1;
      rd_r <= `SLI_RD_RST;
    end else if (tx_bit_r == `SLI_LAST_BIT) begin
      tx_bit_r <= 5'h00;
      tx_frame_r <= tx_frame_nxt;
      tx_oe_n_r <= ~tlk_s_r;
      if (tlk_s_r) begin
        rd_r <= tx_inv ? rd_r - word_disp : rd_r + word_disp;
      end
    end else begin
      tx_bit_r <= tx_bit_r + 5'h01;
      tx_frame_r <= tx_frame_r >> 1;
    end
  end

  assign serial_out_pos = tx_frame_r[0];
  assign serial_out_neg = ~tx_frame_r[0];
  assign serial_out_oe_n = tx_oe_n_r;

  ////////////////////////////////////////////////////////////////////////
  // Serial input and sleep pin pass two flops in the link domain
  always_ff @(posedge link_clk) begin
    rin_pm_r <= serial_in_pos;
    rin_ps_r <= rin_pm_r;
    rin_nm_r <= serial_in_neg;
    rin_ns_r <= rin_nm_r;
    rsl_m_r <= rx_sleep_n;
    rsl_s_r <= rsl_m_r;
  end

  // A floating or shorted pair reads as zero, which never frames
  assign rx_bit = rin_ps_r & ~rin_ns_r;

  // Retiming shift register, first bit ends up at index 0
  always_ff @(posedge link_clk) begin
    if (!lrst_b) begin
      rx_sr_r <= '0;
    end else begin
      rx_sr_r <= {rx_bit, rx_sr_r[`SLI_FRAME_W-1:1]};
    end
  end

  assign rx_ok = sli_frame_ok(rx_sr_r);

  // Hunt, verify a run of frames, then track; clock from data only
  always_ff @(posedge link_clk) begin
    if (!lrst_b || !rsl_s_r) begin
      rx_state_r <= SLI_HUNT;
      rx_cnt_r <= 5'h00;
      rx_good_r <= 3'h0;
    end else begin
      case (rx_state_r)
        SLI_HUNT: begin
          rx_cnt_r <= 5'h00;
          if (rx_ok) begin
            rx_state_r <= SLI_VERIFY;
            rx_good_r <= 3'h1;
          end
        end
        SLI_VERIFY: begin
          rx_cnt_r <= rx_cnt_r + 5'h01;
          if (rx_cnt_r == `SLI_LAST_BIT) begin
            rx_cnt_r <= 5'h00;
            if (!rx_ok) begin
              rx_state_r <= SLI_HUNT;
            end else if (rx_good_r == `SLI_RX_LOCK_FRAMES - 3'h1) begin
              rx_state_r <= SLI_LOCKED;
            end else begin
              rx_good_r <= rx_good_r + 3'h1;
            end
          end
        end
        SLI_LOCKED: begin
          rx_cnt_r <= rx_cnt_r + 5'h01;
          if (rx_cnt_r == `SLI_LAST_BIT) begin
            rx_cnt_r <= 5'h00;
            if (!rx_ok) begin
              rx_state_r <= SLI_HUNT;
            end
          end
        end
        default: begin
          rx_state_r <= SLI_HUNT;
        end
      endcase
    end
  end

  // Words leave only from the tracking state, balance undone
  always_ff @(posedge link_clk) begin
    if (!lrst_b) begin
      rx_emit_r <= 1'b0;
      rx_emit_word_r <= `SLI_WORD_RST;
    end else begin
      rx_emit_r <= (rx_state_r == SLI_LOCKED) &&
                   (rx_cnt_r == `SLI_LAST_BIT) && rx_ok && rsl_s_r;
      rx_emit_word_r <= rx_sr_r[`SLI_POS_BAL-1:`SLI_POS_PAY] ^
                        {`SLI_WORD_W{rx_sr_r[`SLI_POS_BAL]}};
    end
  end

  // One word per 28 bit times, far slower than the handshake
  sli_cdc_word u_rx_cdc (
    .src_clk(link_clk),
    .src_rst_b(lrst_b),
    .src_valid(rx_emit_r),
    .src_data(rx_emit_word_r),
    .src_ready(),
    .dst_clk(clk),
    .dst_rst_b(rst_b),
    .dst_valid(rx_new_v),
    .dst_data(rx_new_word)
  );

  ////////////////////////////////////////////////////////////////////////
  // Lock level and control pins into the system domain
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lk_m_r <= 1'b0;
      lk_s_r <= 1'b0;
    end else begin
      lk_m_r <= (rx_state_r == SLI_LOCKED);
      lk_s_r <= lk_m_r;
    end
  end

  always_ff @(posedge clk) begin
    ctl_m_r <= {spare_config_input, rx_sleep_n, rx_strobe_edge_select,
                rx_output_enable};
    ctl_s_r <= ctl_m_r;
  end

  // Flag waits for the first word so flag and data appear together
  always_comb begin
    rx_lock_nxt = rx_lock_r;
    if (!lk_s_r || !ctl_s_r[2]) begin
      rx_lock_nxt = 1'b0;
    end else if (rx_new_v) begin
      rx_lock_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_lock_r <= 1'b0;
      rx_oe_n_r <= 1'b1;
    end else begin
      rx_lock_r <= rx_lock_nxt;
      rx_oe_n_r <= ~(rx_lock_nxt & ctl_s_r[0] &
                     ~ctl_s_r[3]);
    end
  end

  // Word register and recovered clock; strobe edge lands two cycles after the word
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      word_out_r <= `SLI_WORD_RST;
      rclk_r <= 1'b0;
      half_cnt_r <= 3'h0;
    end else if (rx_new_v && lk_s_r) begin
      word_out_r <= rx_new_word;
      rclk_r <= ~ctl_s_r[1];
      half_cnt_r <= 3'h1;
    end else if (half_cnt_r == `SLI_RCLK_HALF) begin
      rclk_r <= ctl_s_r[1];
      half_cnt_r <= 3'h0;
    end else if (half_cnt_r != 3'h0) begin
      half_cnt_r <= half_cnt_r + 3'h1;
    end
  end

  assign parallel_word_out = word_out_r;
  assign recovered_clock_out = rclk_r;
  assign rx_outputs_oe_n = rx_oe_n_r;
  assign rx_lock = rx_lock_r;

endmodule

`default_nettype wire

// ---- dv/sli_top_monitor.sv ----
/*
 Checker of sli_top port behaviour.
 Assumes it is bound to sli_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module sli_top_monitor (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic link_clk,
  input wire logic transmit_word_clock,
  input wire logic serial_out_pos,
  input wire logic serial_out_neg,
  input wire logic serial_out_oe_n,
  input wire logic tx_locked,
  input wire logic rx_output_enable,
  input wire logic rx_strobe_edge_select,
  input wire logic rx_sleep_n,
  input wire sli_pkg::sli_word_t parallel_word_out,
  input wire logic recovered_clock_out,
  input wire logic rx_outputs_oe_n,
  input wire logic rx_lock
);
  import sli_pkg::*;
  logic [7:0] still_r;
  logic wclk_r;

  //////////////////////////////
  // Cycles since the word clock pin last moved, saturating
  always_ff @(posedge clk) begin
    wclk_r <= transmit_word_clock;
    if (!rst_b || transmit_word_clock != wclk_r) begin
      still_r <= 8'h00;
    end else if (still_r != 8'hff) begin
      still_r <= still_r + 8'h01;
    end
  end

  //////////////////////////////
  // Receiver gating; one cycle of slack as lock and enable are registers
  lock_gates_out_a: assert property (
    @(posedge clk) disable iff (!rst_b) (!rx_lock) [*2] |-> rx_outputs_oe_n)
    else $error("outputs driven while unlocked");
  lock_rise_drive_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    $rose(rx_lock) && rx_output_enable && rx_sleep_n |-> !rx_outputs_oe_n)
    else $error("lock rose without outputs");
  strobe_edge_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    rx_lock && $changed(parallel_word_out)
    |-> recovered_clock_out != rx_strobe_edge_select
    ##2 recovered_clock_out == rx_strobe_edge_select)
    else $error("strobe edge misplaced");
  sleep_drops_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (!rx_sleep_n) [*4] |-> !rx_lock && rx_outputs_oe_n)
    else $error("sleep did not drop lock");
  enable_float_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    $fell(rx_output_enable) |-> ##[1:4] rx_outputs_oe_n)
    else $error("enable low did not float");
  enable_keeps_lock_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    $fell(rx_output_enable) && rx_lock |=> rx_lock [*4])
    else $error("enable low dropped lock");

  //////////////////////////////
  // Transmitter lock and line framing
  float_until_lock_a: assert property (
    @(posedge clk) disable iff (!rst_b) $fell(serial_out_oe_n) |-> tx_locked)
    else $error("serial driven before lock");
  word_clock_loss_a: assert property (
    @(posedge clk) disable iff (!rst_b) still_r == 8'h5a |-> !tx_locked)
    else $error("lock held without word clock");
  frame_shape_a: assert property (
    @(posedge link_clk) disable iff (!rst_b)
    $fell(serial_out_oe_n) |-> serial_out_pos ##27 !serial_out_pos
    ##1 (serial_out_pos || serial_out_oe_n))
    else $error("frame bounds wrong");
  pair_inverse_a: assert property (
    @(posedge link_clk) disable iff (!rst_b)
    !serial_out_oe_n |-> serial_out_neg != serial_out_pos)
    else $error("line pair not inverse");
endmodule

bind sli_top sli_top_monitor i_sli_top_monitor (
  .clk(clk), .rst_b(rst_b), .link_clk(link_clk),
  .transmit_word_clock(transmit_word_clock),
  .serial_out_pos(serial_out_pos), .serial_out_neg(serial_out_neg),
  .serial_out_oe_n(serial_out_oe_n), .tx_locked(tx_locked),
  .rx_output_enable(rx_output_enable),
  .rx_strobe_edge_select(rx_strobe_edge_select),
  .rx_sleep_n(rx_sleep_n), .parallel_word_out(parallel_word_out),
  .recovered_clock_out(recovered_clock_out),
  .rx_outputs_oe_n(rx_outputs_oe_n), .rx_lock(rx_lock));

`default_nettype wire

// ---- dv/sli_far_tx.sv ----
/*
 Far-end serializer model driving the receiver's serial pair.
 Assumes link_clk runs continuously as the line bit clock.
*/
`timescale 1ns/1ps
`default_nettype none

module sli_far_tx (
  input wire logic link_clk,
  input wire logic rst_b,
  input wire sli_pkg::sli_word_t feed_word,
  input wire logic break_one,
  output logic serial_pos,
  output logic serial_neg,
  output sli_pkg::sli_word_t cur_word,
  output sli_pkg::sli_word_t prev_word
);
  import sli_pkg::*;
  logic [4:0] bit_r;
  logic [27:0] shift_r;
  logic signed [7:0] rd_r;
  logic inv;

  // Ones minus zeros of a payload word
  function automatic logic signed [7:0] disp(input sli_word_t w);
    logic signed [7:0] d;
    d = 8'sh00;
    for (int i = 0; i < 24; i++) begin
      d = d + (w[i] ? 8'sh01 : -8'sh01);
    end
    return d;
  endfunction

  // Invert when the word pushes disparity further the same way
  function automatic logic balance(input logic signed [7:0] rd,
                                   input sli_word_t w);
    return (rd > 0 && disp(w) > 0) || (rd < 0 && disp(w) < 0);
  endfunction

  // Whole frame, bit 0 first on the line
  function automatic logic [27:0] frame_of(input sli_word_t w,
                                           input logic iv);
    sli_word_t p;
    p = w ^ {24{iv}};
    return {1'b0, ^{p, iv}, iv, p, 1'b1};
  endfunction

  assign inv = balance(rd_r, feed_word);
  assign serial_pos = shift_r[0];
  assign serial_neg = ~shift_r[0];

  //////////////////////////////
  // Frames back to back; a broken one lacks its embedded edge
  always_ff @(posedge link_clk) begin
    if (!rst_b) begin
      bit_r <= 5'h1b;
      rd_r <= 8'sh00;
      shift_r <= 28'h0000000;
      cur_word <= 24'h000000;
      prev_word <= 24'h000000;
    end else if (bit_r == 5'h1b) begin
      shift_r <= frame_of(feed_word, inv) & ~{27'h0, break_one};
      rd_r <= inv ? rd_r - disp(feed_word) : rd_r + disp(feed_word);
      prev_word <= cur_word;
      cur_word <= feed_word;
      bit_r <= 5'h00;
    end else begin
      shift_r <= shift_r >> 1;
      bit_r <= bit_r + 5'h01;
    end
  end
endmodule

`default_nettype wire

// ---- dv/sli_top_test.sv ----
/*
 Self-checking bench for sli_top with a far-end serializer model.
 Assumes sli_pkg compiled first and the checker bound to sli_top.
*/
`timescale 1ns/1ps
`default_nettype none

module sli_top_test;
  import sli_pkg::*;
  logic clk, rst_b, link_clk, transmit_word_clock, break_one, tx_chk;
  logic serial_out_pos, serial_out_neg, serial_out_oe_n, tx_locked;
  logic serial_in_pos, serial_in_neg, rx_output_enable, rx_lock;
  logic rx_strobe_edge_select, rx_sleep_n, recovered_clock_out;
  logic rx_outputs_oe_n;
  sli_word_t tx_word_in, feed_word, cur_word, prev_word, last_out, tw;
  sli_word_t parallel_word_out;
  integer seed;
  int err_total, comparisons, hi_cnt, lo_cnt, ph, tcnt;
  logic [27:0] tfr;
  logic signed [7:0] trd;

  sli_top i_sli_top (.clk(clk), .rst_b(rst_b), .link_clk(link_clk),
    .transmit_word_clock(transmit_word_clock), .tx_word_in(tx_word_in),
    .serial_out_pos(serial_out_pos), .serial_out_neg(serial_out_neg),
    .serial_out_oe_n(serial_out_oe_n), .tx_locked(tx_locked),
    .serial_in_pos(serial_in_pos), .serial_in_neg(serial_in_neg),
    .rx_output_enable(rx_output_enable),
    .rx_strobe_edge_select(rx_strobe_edge_select),
    .rx_sleep_n(rx_sleep_n), .spare_config_input(1'b0),
    .parallel_word_out(parallel_word_out),
    .recovered_clock_out(recovered_clock_out),
    .rx_outputs_oe_n(rx_outputs_oe_n), .rx_lock(rx_lock));

  sli_far_tx i_sli_far_tx (.link_clk(link_clk), .rst_b(rst_b),
    .feed_word(feed_word), .break_one(break_one),
    .serial_pos(serial_in_pos), .serial_neg(serial_in_neg),
    .cur_word(cur_word), .prev_word(prev_word));

  //////////////////////////////
  // Two unrelated clocks
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #6 link_clk = ~link_clk;
  end

  // Word clock from high and low counts; new far-end word once loaded
  always @(posedge clk) begin
    ph = ph + 1;
    if (ph >= (transmit_word_clock ? hi_cnt : lo_cnt)) begin
      ph = 0;
      transmit_word_clock <= ~transmit_word_clock;
    end
    if (cur_word === feed_word) feed_word <= 24'($random(seed));
  end

  // Received words must be the far end's last completed frame
  always @(posedge clk) begin
    if (rx_lock === 1'b1 && parallel_word_out !== last_out) begin
      chk({4'h0, parallel_word_out}, {4'h0, prev_word});
    end
    last_out = parallel_word_out;
  end

  // Driven line frames: shape, parity, balance and payload
  always @(posedge link_clk) begin
    if (serial_out_oe_n !== 1'b0) begin
      tcnt = 0;
    end else begin
      tfr[tcnt] = serial_out_pos;
      tcnt = tcnt + 1;
      if (tcnt == 28) begin
        tcnt = 0;
        tw = tfr[24:1] ^ {24{tfr[25]}};
        chk(tfr, i_sli_far_tx.frame_of(tw,
            i_sli_far_tx.balance(trd, tw)));
        if (tx_chk) chk({4'h0, tw}, {4'h0, tx_word_in});
        trd = tfr[25] ? trd - i_sli_far_tx.disp(tw)
                      : trd + i_sli_far_tx.disp(tw);
      end
    end
  end

  //////////////////////////////
  task automatic chk(input logic [27:0] got, input logic [27:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic cond(input int k);
    case (k)
      0: return tx_locked === 1'b1;
      1: return rx_lock === 1'b1;
      default: return rx_lock === 1'b0;
    endcase
  endfunction

  // Bounded wait; running out counts as a mismatch
  task automatic wait_on(input int k, input int lim);
    int n;
    n = 0;
    while (!cond(k) && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (!cond(k)) begin
      err_total++;
      end_sim();
    end
  endtask

  task automatic set_wclk(input int hi, input int lo, input int n,
                          input logic exp);
    #1;
    hi_cnt = hi;
    lo_cnt = lo;
    repeat (n) @(posedge clk);
    #1;
    chk({27'h0, tx_locked}, {27'h0, exp});
  endtask

  task automatic end_sim;
    if (err_total == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  //////////////////////////////
  // Main sequence
  initial begin
    seed = 26012;
    err_total = 0;
    comparisons = 0;
    ph = 0;
    tcnt = 0;
    trd = 8'sh00;
    hi_cnt = 5;
    lo_cnt = 5;
    tx_chk = 1'b0;
    break_one = 1'b0;
    rst_b = 1'b0;
    transmit_word_clock = 1'b0;
    tx_word_in = 24'h000000;
    feed_word = 24'hffffff;
    rx_output_enable = 1'b1;
    rx_strobe_edge_select = 1'b1;
    rx_sleep_n = 1'b1;
    repeat (19) @(posedge clk);
    #1;
    chk({24'h0, serial_out_oe_n, rx_outputs_oe_n, tx_locked, rx_lock},
        28'hc);
    @(posedge clk);
    rst_b <= 1'b1;
    wait_on(0, 400);
    wait_on(1, 4000);
    chk({27'h0, rx_outputs_oe_n}, 28'h0);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      tx_word_in <= (i == 0) ? 24'hffffff : (i == 1) ? 24'h000001
                  : 24'($random(seed));
      repeat (250) @(posedge clk);
      tx_chk = 1'b1;
      repeat (150) @(posedge clk);
      tx_chk = 1'b0;
    end
    @(posedge clk);
    rx_output_enable <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    chk({26'h0, rx_outputs_oe_n, rx_lock}, 28'h3);
    @(posedge clk);
    rx_output_enable <= 1'b1;
    rx_sleep_n <= 1'b0;
    repeat (8) @(posedge clk);
    rx_strobe_edge_select <= 1'b0;
    #1;
    chk({26'h0, rx_outputs_oe_n, rx_lock}, 28'h2);
    @(posedge clk);
    rx_sleep_n <= 1'b1;
    wait_on(1, 4000);
    @(posedge clk);
    break_one <= 1'b1;
    repeat (70) @(posedge clk);
    break_one <= 1'b0;
    wait_on(2, 300);
    wait_on(1, 4000);
    set_wclk(3, 2, 300, 1'b1);
    set_wclk(33, 33, 1500, 1'b1);
    set_wclk(2, 2, 200, 1'b0);
    set_wclk(5, 5, 300, 1'b1);
    set_wclk(100000, 5, 300, 1'b0);
    set_wclk(5, 5, 300, 1'b1);
    end_sim();
  end
endmodule

`default_nettype wire
